// File: rtl/gtc_pkg.sv
// Package: register map, field positions and reset values of the gated timer control
package gtc_pkg;
    localparam int GTC_NUM_TIMERS = 3;
    localparam int GTC_ADDR_W = 8;
    // Register byte offsets; per-timer block of 0x10 bytes starting at 0x00
    localparam logic [7:0] GTC_TIMER_STRIDE = 8'h10;
    localparam logic [3:0] GTC_OFS_CONTROL = 4'h0;
    localparam logic [3:0] GTC_OFS_GATE = 4'h4;
    localparam logic [3:0] GTC_OFS_COUNT_LOW = 4'h8;
    localparam logic [3:0] GTC_OFS_COUNT_HIGH = 4'hc;
    localparam logic [7:0] GTC_OFS_IRQ_STATUS = 8'h30;
    localparam logic [7:0] GTC_OFS_IRQ_ENABLE = 8'h34;
    localparam logic [7:0] GTC_OFS_IRQ_CLEAR = 8'h38;
    // Control register fields
    localparam int GTC_CTL_ENABLE = 0;
    localparam int GTC_CTL_WIDE = 1;
    localparam int GTC_CTL_SYNC = 2;
    localparam int GTC_CTL_DIV_LO = 4;
    localparam logic [7:0] GTC_CTL_WRITE_MASK = 8'h37;
    localparam logic [7:0] GTC_CTL_RESET = 8'h00;
    // Gate register fields
    localparam int GTC_GATE_ENABLE = 7;
    localparam int GTC_GATE_POL = 6;
    localparam int GTC_GATE_TOGGLE = 5;
    localparam int GTC_GATE_SINGLE = 4;
    localparam int GTC_GATE_GO = 3;
    localparam int GTC_GATE_LEVEL = 2;
    localparam logic [7:0] GTC_GATE_WRITE_MASK = 8'hf8;
    localparam logic [7:0] GTC_GATE_RESET = 8'h00;
    // Clock source codes
    localparam logic [1:0] GTC_SRC_SYS = 2'h0;
    localparam logic [1:0] GTC_SRC_SYS_QUARTER = 2'h1;
    localparam logic [1:0] GTC_SRC_EXT = 2'h2;
    localparam logic [1:0] GTC_QUARTER_LAST = 2'h3;
    localparam logic [2:0] GTC_DIV_RESET = 3'h0;
    // Interrupt status bits per timer: [0] gate event, [1] overflow
    localparam int GTC_IRQ_BITS = 2;
    typedef enum logic [1:0] {
        GTC_PULSE_IDLE = 2'b00,
        GTC_PULSE_ARMED = 2'b01,
        GTC_PULSE_COUNTING = 2'b11
    } gtc_pulse_t;
endpackage : gtc_pkg

// File: rtl/gtc_gated_timer.sv
// Three gated 16-bit timers with control, gate and interrupt registers on AHB-Lite
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
// What this block does
// - Single-pulse counting starts on rising gate edge
// - Falling gate level clears acquisition go bit
// - Falling gate level sets gate event flag
// - Prescale codes 11, 10, 00 divide 8, 4, 1
// - Sync bit ignored for system clock sources
// - Sync bit set bypasses external clock synchronisation
// - Wide mode buffers high byte for 16-bit access
// - Narrow mode accesses bytes independently
// - Enable starts timer; clearing clears toggle
// - Unimplemented control bits read zero
// - Control and gate bits reset to zero on power resets
// - Three identical timers with own controls
// - Toggle flop held clear unless toggle mode
// - No counting after pulse until re-armed
module gtc_gated_timer (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic POWER_RST_IN,
    input wire logic HSEL_IN,
    input wire logic [gtc_pkg::GTC_ADDR_W-1:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HWDATA_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic [gtc_pkg::GTC_NUM_TIMERS-1:0] EXT_CLK_IN,
    input wire logic [gtc_pkg::GTC_NUM_TIMERS-1:0] GATE_SRC_IN,
    output logic [gtc_pkg::GTC_NUM_TIMERS-1:0] OVERFLOW_OUT,
    output logic IRQ_OUT
);
    import gtc_pkg::*;

    localparam int NT = GTC_NUM_TIMERS;

    // Bus address phase capture
    logic wr_pend;
    logic [GTC_ADDR_W-1:0] wr_addr;
    logic bus_go;
    assign bus_go = HSEL_IN && HREADY_IN && HTRANS_IN[1];

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= bus_go && HWRITE_IN;
            if (bus_go) begin
                wr_addr <= HADDR_IN;
            end
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end
    end

    logic [NT-1:0][7:0] control;
    logic [NT-1:0][7:0] gate_reg;
    logic [NT-1:0][15:0] count;
    logic [NT-1:0][7:0] high_buf;
    logic [NT-1:0] gate_level;
    logic [NT*GTC_IRQ_BITS-1:0] irq_status;
    logic [NT*GTC_IRQ_BITS-1:0] irq_enable;
    logic [NT*GTC_IRQ_BITS-1:0] gate_evt;
    logic [NT*GTC_IRQ_BITS-1:0] irq_clr;

    assign irq_clr = (wr_pend && wr_addr == GTC_OFS_IRQ_CLEAR) ?
        HWDATA_IN[NT*GTC_IRQ_BITS-1:0] : '0;

    genvar t;
    generate
        for (t = 0; t < NT; t++) begin : g_timer
            logic sel;
            logic wr_ctl;
            logic wr_gate;
            logic wr_lo;
            logic wr_hi;
            logic [7:0] wdat;
            logic ext_s1;
            logic ext_s2;
            logic ext_d;
            logic src_raw;
            logic src_prev;
            logic src_edge;
            logic [2:0] div_cnt;
            logic [2:0] div_last;
            logic tick;
            logic gate_raw;
            logic gate_prev;
            logic toggle_ff;
            logic gate_val;
            logic gate_val_prev;
            logic gate_rise;
            logic gate_fall;
            logic [1:0] src_sel;
            gtc_pulse_t pulse_state;
            gtc_pulse_t next_pulse_state;
            logic gate_open;
            logic wrap;

            assign sel = (wr_addr[7:4] == 4'(t));
            assign wdat = HWDATA_IN[7:0];
            assign wr_ctl = wr_pend && sel && wr_addr[3:0] == GTC_OFS_CONTROL;
            assign wr_gate = wr_pend && sel && wr_addr[3:0] == GTC_OFS_GATE;
            assign wr_lo = wr_pend && sel && wr_addr[3:0] == GTC_OFS_COUNT_LOW;
            assign wr_hi = wr_pend && sel && wr_addr[3:0] == GTC_OFS_COUNT_HIGH;

            // Control: only power resets clear it, other resets keep it
            always_ff @(posedge CLK_IN) begin
                if (POWER_RST_IN) begin
                    control[t] <= GTC_CTL_RESET;
                end else if (wr_ctl) begin
                    control[t] <= wdat & GTC_CTL_WRITE_MASK;
                end
            end

            // Gate register; bits [1:0] carry the clock source select
            always_ff @(posedge CLK_IN) begin
                if (POWER_RST_IN) begin
                    gate_reg[t] <= GTC_GATE_RESET;
                    src_sel <= GTC_SRC_SYS;
                end else begin
                    if (wr_gate) begin
                        gate_reg[t] <= wdat & GTC_GATE_WRITE_MASK;
                        src_sel <= wdat[1:0];
                    end
                    // Hardware clear wins over a simultaneous software set only while go is already set
                    if (gate_fall && gate_reg[t][GTC_GATE_GO]) begin
                        gate_reg[t][GTC_GATE_GO] <= 1'b0;
                    end
                    if (!gate_reg[t][GTC_GATE_SINGLE] && !(wr_gate && wdat[GTC_GATE_SINGLE])) begin
                        gate_reg[t][GTC_GATE_GO] <= 1'b0;
                    end
                end
            end

            // External clock: second flop only read when the sync bit is clear
            always_ff @(posedge CLK_IN) begin
                if (RST_IN) begin
                    ext_s1 <= 1'b0;
                    ext_s2 <= 1'b0;
                    src_prev <= 1'b0;
                end else begin
                    ext_s1 <= EXT_CLK_IN[t];
                    ext_s2 <= ext_s1;
                    src_prev <= src_raw;
                end
            end
            // Unsynchronised path samples the pin directly; inputs count as synchronous
            assign ext_d = control[t][GTC_CTL_SYNC] ? EXT_CLK_IN[t] : ext_s2;

            // System sources ignore the sync bit entirely
            always_comb begin
                src_raw = 1'b0;
                src_edge = 1'b0;
                case (src_sel)
                    GTC_SRC_SYS: begin
                        src_edge = 1'b1;
                    end
                    GTC_SRC_SYS_QUARTER: begin
                        src_edge = (div_cnt[1:0] == GTC_QUARTER_LAST);
                    end
                    default: begin
                        src_raw = ext_d;
                        src_edge = ext_d && !src_prev;
                    end
                endcase
            end

            // Prescaler 1:1, 1:2, 1:4, 1:8
            always_comb begin
                case (control[t][GTC_CTL_DIV_LO +: 2])
                    2'h0: div_last = 3'h0;
                    2'h1: div_last = 3'h1;
                    2'h2: div_last = 3'h3;
                    default: div_last = 3'h7;
                endcase
            end

            logic [2:0] qdiv;
            logic [2:0] pre_cnt;
            assign div_cnt = qdiv;
            always_ff @(posedge CLK_IN) begin
                if (RST_IN) begin
                    qdiv <= GTC_DIV_RESET;
                    pre_cnt <= GTC_DIV_RESET;
                end else begin
                    qdiv <= qdiv + 3'h1;
                    if (!control[t][GTC_CTL_ENABLE]) begin
                        pre_cnt <= GTC_DIV_RESET;
                    end else if (src_edge) begin
                        pre_cnt <= (pre_cnt >= div_last) ? GTC_DIV_RESET : pre_cnt + 3'h1;
                    end
                end
            end
            assign tick = src_edge && control[t][GTC_CTL_ENABLE] && pre_cnt >= div_last;

            // Gate path: polarity, then toggle flop
            assign gate_raw = GATE_SRC_IN[t] ^ gate_reg[t][GTC_GATE_POL];
            always_ff @(posedge CLK_IN) begin
                if (RST_IN) begin
                    gate_prev <= 1'b0;
                    toggle_ff <= 1'b0;
                    gate_val_prev <= 1'b0;
                end else begin
                    gate_prev <= gate_raw;
                    gate_val_prev <= gate_val;
                    if (!gate_reg[t][GTC_GATE_TOGGLE] || !control[t][GTC_CTL_ENABLE]) begin
                        toggle_ff <= 1'b0;
                    end else if (gate_raw && !gate_prev) begin
                        toggle_ff <= !toggle_ff;
                    end
                end
            end
            assign gate_val = gate_reg[t][GTC_GATE_TOGGLE] ? toggle_ff : gate_raw;
            assign gate_rise = gate_val && !gate_val_prev;
            assign gate_fall = !gate_val && gate_val_prev;
            assign gate_level[t] = gate_val;

            // Single-pulse acquisition
            always_comb begin
                next_pulse_state = pulse_state;
                case (pulse_state)
                    GTC_PULSE_IDLE: begin
                        if (gate_reg[t][GTC_GATE_GO]) begin
                            next_pulse_state = GTC_PULSE_ARMED;
                        end
                    end
                    GTC_PULSE_ARMED: begin
                        if (!gate_reg[t][GTC_GATE_GO]) begin
                            next_pulse_state = GTC_PULSE_IDLE;
                        end else if (gate_rise) begin
                            next_pulse_state = GTC_PULSE_COUNTING;
                        end
                    end
                    GTC_PULSE_COUNTING: begin
                        if (gate_fall || !gate_reg[t][GTC_GATE_GO]) begin
                            next_pulse_state = GTC_PULSE_IDLE;
                        end
                    end
                    default: next_pulse_state = GTC_PULSE_IDLE;
                endcase
            end
            always_ff @(posedge CLK_IN) begin
                if (RST_IN || !gate_reg[t][GTC_GATE_SINGLE]) begin
                    pulse_state <= GTC_PULSE_IDLE;
                end else begin
                    pulse_state <= next_pulse_state;
                end
            end

            always_comb begin
                if (!gate_reg[t][GTC_GATE_ENABLE]) begin
                    gate_open = 1'b1;
                end else if (gate_reg[t][GTC_GATE_SINGLE]) begin
                    gate_open = (pulse_state == GTC_PULSE_COUNTING) && gate_val;
                end else begin
                    gate_open = gate_val;
                end
            end

            // Counter and high-byte buffer
            assign wrap = tick && gate_open && count[t] == 16'hffff;
            always_ff @(posedge CLK_IN) begin
                if (RST_IN) begin
                    count[t] <= '0;
                    high_buf[t] <= '0;
                end else begin
                    if (wr_lo) begin
                        if (control[t][GTC_CTL_WIDE]) begin
                            count[t] <= {high_buf[t], wdat};
                        end else begin
                            count[t][7:0] <= wdat;
                        end
                    end else if (wr_hi) begin
                        if (control[t][GTC_CTL_WIDE]) begin
                            high_buf[t] <= wdat;
                        end else begin
                            count[t][15:8] <= wdat;
                        end
                    end else if (tick && gate_open) begin
                        count[t] <= count[t] + 16'h1;
                    end
                    // Low-byte read snapshots the high byte in wide mode
                    if (bus_go && !HWRITE_IN && HADDR_IN[7:4] == 4'(t)
                        && HADDR_IN[3:0] == GTC_OFS_COUNT_LOW && control[t][GTC_CTL_WIDE]) begin
                        high_buf[t] <= count[t][15:8];
                    end
                end
            end

            always_ff @(posedge CLK_IN) begin
                if (RST_IN) begin
                    OVERFLOW_OUT[t] <= 1'b0;
                end else begin
                    OVERFLOW_OUT[t] <= wrap;
                end
            end

            assign gate_evt[GTC_IRQ_BITS*t] = gate_fall;
            assign gate_evt[GTC_IRQ_BITS*t+1] = wrap;
        end
    endgenerate

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            irq_status <= '0;
            irq_enable <= '0;
            IRQ_OUT <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | gate_evt;
            if (wr_pend && wr_addr == GTC_OFS_IRQ_ENABLE) begin
                irq_enable <= HWDATA_IN[NT*GTC_IRQ_BITS-1:0];
            end
            IRQ_OUT <= |(((irq_status & ~irq_clr) | gate_evt) & irq_enable);
        end
    end

    // Read data, registered in the data phase
    logic [7:0] rd_byte;
    logic [3:0] rd_tmr;
    assign rd_tmr = HADDR_IN[7:4];
    always_comb begin
        rd_byte = 8'h00;
        if (rd_tmr < 4'(NT)) begin
            case (HADDR_IN[3:0])
                GTC_OFS_CONTROL: rd_byte = control[rd_tmr[1:0]];
                GTC_OFS_GATE: rd_byte = gate_reg[rd_tmr[1:0]] |
                    {5'h00, gate_level[rd_tmr[1:0]], 2'h0};
                GTC_OFS_COUNT_LOW: rd_byte = count[rd_tmr[1:0]][7:0];
                GTC_OFS_COUNT_HIGH: rd_byte = control[rd_tmr[1:0]][GTC_CTL_WIDE] ?
                    high_buf[rd_tmr[1:0]] : count[rd_tmr[1:0]][15:8];
                default: rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            HRDATA_OUT <= '0;
        end else if (bus_go && !HWRITE_IN) begin
            case (HADDR_IN)
                GTC_OFS_IRQ_STATUS: HRDATA_OUT <= {26'h0, irq_status};
                GTC_OFS_IRQ_ENABLE: HRDATA_OUT <= {26'h0, irq_enable};
                default: HRDATA_OUT <= {24'h0, rd_byte};
            endcase
        end
    end
endmodule : gtc_gated_timer

// File: verif/gtc_gated_timer_chk.sv
// Checker for the bus answers and the interrupt output of the gated timer block
`timescale 1ns/10ps
module gtc_gated_timer_chk (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic HSEL_IN,
    input wire logic [gtc_pkg::GTC_ADDR_W-1:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic IRQ_OUT
);
    import gtc_pkg::*;
    logic rd_take;
    assign rd_take = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN;
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);
    sequence ctl_rd;
        rd_take && (HADDR_IN < GTC_OFS_IRQ_STATUS) && (HADDR_IN[3:0] == GTC_OFS_CONTROL);
    endsequence
    sequence gate_rd;
        rd_take && (HADDR_IN < GTC_OFS_IRQ_STATUS) && (HADDR_IN[3:0] == GTC_OFS_GATE);
    endsequence
    a_hready_high: assert property (HREADYOUT_OUT)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!HRESP_OUT)
        else $error("slave answered with an error response");
    a_ctl_zero_bits: assert property (ctl_rd |=> HRDATA_OUT[31:6] == 0 && !HRDATA_OUT[3])
        else $error("control read shows an unimplemented bit");
    a_gate_low_bits: assert property (gate_rd |=> HRDATA_OUT[31:8] == 0 && HRDATA_OUT[1:0] == 0)
        else $error("gate read shows write-only source bits");
    a_status_width: assert property (rd_take && HADDR_IN == GTC_OFS_IRQ_STATUS
        |=> HRDATA_OUT[31:6] == 0)
        else $error("status read shows bits beyond the three timers");
    a_unmapped_zero: assert property (rd_take && HADDR_IN >= 8'h3c |=> HRDATA_OUT == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_rdata_hold: assert property (!rd_take |=> $stable(HRDATA_OUT))
        else $error("read data changed without a read request");
    a_irq_reset: assert property ($fell(RST_IN) |-> !IRQ_OUT ##1 !IRQ_OUT)
        else $error("interrupt high straight after reset");
endmodule : gtc_gated_timer_chk

bind gtc_gated_timer gtc_gated_timer_chk u_gtc_gated_timer_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
    .HRESP_OUT(HRESP_OUT), .IRQ_OUT(IRQ_OUT));

// File: verif/test_gtc_gated_timer.sv
// Self-checking testbench for the gated timer block
`timescale 1ns/10ps
module test_gtc_gated_timer;
    import gtc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic prst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] ext_clk = 3'h0;
    logic [2:0] gate_src = 3'h0;
    logic [31:0] hrdata;
    logic hready;
    logic irq;
    logic [2:0] ovf;
    int ovf_count = 0;
    int errors = 0;
    int checks_done = 0;
    logic [31:0] v;
    logic [31:0] c0;
    logic [31:0] c1;

    gtc_gated_timer u_gtc_gated_timer (.CLK_IN(clk), .RST_IN(rst), .POWER_RST_IN(prst),
        .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'h2), .HREADY_IN(hready), .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(), .EXT_CLK_IN(ext_clk), .GATE_SRC_IN(gate_src),
        .OVERFLOW_OUT(ovf), .IRQ_OUT(irq));

    initial begin
        forever #5 clk = ~clk;
    end

    // Counts overflow pulses of timer 0; a pulse counts once for every cycle it stays high
    always @(posedge clk) begin
        if (ovf[0] === 1'b1) begin
            ovf_count <= ovf_count + 1;
        end
    end

    task final_report;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task cmp(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : cmp

    task near(input string name, input logic [31:0] seen, input int exp);
        cmp(name, 32'(seen + 2 >= exp && seen <= exp + 2), 32'h1);
    endtask : near

    // Bounded wait for the edge at which the slave signals ready
    task wait_ready;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            errors++;
            $display("[FAIL] bus ready expected 1 seen timeout");
            final_report();
        end
    endtask : wait_ready

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        wait_ready();
        q = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        bus(1'b1, a, d, junk);
    endtask : wr

    task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, v);
        cmp(name, v, exp);
    endtask : rd

    // Runs timer 1 for eight external clock periods of eight cycles each
    task run(input logic [7:0] ctl, input logic [7:0] gate, output logic [31:0] q);
        wr(8'h10, 32'h0);
        wr(8'h18, 32'h0);
        wr(8'h1c, 32'h0);
        wr(8'h14, gate);
        wr(8'h10, ctl);
        repeat (8) begin
            ext_clk[1] <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clk[1] <= 1'b0;
            repeat (4) @(posedge clk);
        end
        wr(8'h10, 32'h0);
        bus(1'b0, 8'h18, 32'h0, q);
    endtask : run

    task gate_pulse(input int t);
        gate_src[t] <= 1'b1;
        repeat (8) @(posedge clk);
        gate_src[t] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : gate_pulse

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        prst <= 1'b0;
        @(posedge clk);
        for (int t = 0; t < 3; t++) begin
            rd("control reset", 8'(t * 16), 32'h0);
            rd("gate reset", 8'(t * 16 + 4), 32'h0);
            wr(8'(t * 16), 32'(32'hc8 | (t + 1)));
        end
        for (int t = 0; t < 3; t++) rd("control write", 8'(t * 16), 32'(t + 1));
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int t = 0; t < 3; t++) rd("control kept", 8'(t * 16), 32'(t + 1));
        prst <= 1'b1;
        @(posedge clk);
        prst <= 1'b0;
        @(posedge clk);
        for (int t = 0; t < 3; t++) rd("control cleared", 8'(t * 16), 32'h0);
        rd("unmapped", 8'h3c, 32'h0);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            run(8'(c * 16 + 1), 8'h00, c0);
            near("prescale count", c0, 66 >> c);
        end
        for (int s = 1; s < 3; s++) begin
            for (int y = 0; y < 2; y++) begin
                run(8'(y * 4 + 1), 8'(s), c0);
                near("clock source count", c0, (s == 1) ? 16 : 8);
            end
        end
        // Keep the external clock running so a timer that fails to stop is seen
        repeat (4) begin
            ext_clk[1] <= ~ext_clk[1];
            repeat (4) @(posedge clk);
        end
        bus(1'b0, 8'h18, 32'h0, c1);
        cmp("stopped count", c1, c0);
        $display("test clocking done");
        wr(8'h20, 32'h02);
        wr(8'h2c, 32'h12);
        wr(8'h28, 32'h34);
        rd("wide low", 8'h28, 32'h34);
        rd("wide high", 8'h2c, 32'h12);
        wr(8'h2c, 32'h77);
        rd("wide low again", 8'h28, 32'h34);
        rd("wide high snapshot", 8'h2c, 32'h12);
        wr(8'h20, 32'h00);
        wr(8'h2c, 32'h56);
        rd("narrow high", 8'h2c, 32'h56);
        rd("narrow low", 8'h28, 32'h34);
        $display("test wide access done");
        wr(GTC_OFS_IRQ_CLEAR, 32'h3f);
        wr(8'h08, 32'h0);
        wr(8'h0c, 32'h0);
        // Gate already high when armed: without a new rising edge nothing counts
        gate_src[0] <= 1'b1;
        wr(8'h04, 32'h98);
        wr(8'h00, 32'h01);
        rd("armed gate", 8'h04, 32'h9c);
        bus(1'b0, 8'h08, 32'h0, c0);
        repeat (10) @(posedge clk);
        rd("armed count", 8'h08, c0);
        gate_src[0] <= 1'b0;
        repeat (4) @(posedge clk);
        wr(8'h04, 32'h98);
        repeat (4) @(posedge clk);
        gate_src[0] <= 1'b1;
        repeat (10) @(posedge clk);
        bus(1'b0, 8'h08, 32'h0, c1);
        cmp("counting", 32'(c1 != c0), 32'h1);
        gate_src[0] <= 1'b0;
        repeat (8) @(posedge clk);
        rd("go cleared", 8'h04, 32'h90);
        rd("event flag", GTC_OFS_IRQ_STATUS, 32'h1);
        cmp("irq masked", 32'(irq), 32'h0);
        wr(GTC_OFS_IRQ_ENABLE, 32'h1);
        repeat (3) @(posedge clk);
        cmp("irq raised", 32'(irq), 32'h1);
        bus(1'b0, 8'h08, 32'h0, c0);
        gate_pulse(0);
        rd("no second count", 8'h08, c0);
        wr(GTC_OFS_IRQ_CLEAR, 32'h1);
        rd("flag cleared", GTC_OFS_IRQ_STATUS, 32'h0);
        repeat (3) @(posedge clk);
        cmp("irq dropped", 32'(irq), 32'h0);
        $display("test single pulse done");
        wr(8'h04, 32'ha0);
        gate_pulse(0);
        rd("toggle high", 8'h04, 32'ha4);
        gate_pulse(0);
        rd("toggle low", 8'h04, 32'ha0);
        gate_pulse(0);
        rd("toggle high again", 8'h04, 32'ha4);
        wr(8'h00, 32'h00);
        repeat (4) @(posedge clk);
        rd("toggle cleared", 8'h04, 32'ha0);
        $display("test toggle done");
        wr(8'h04, 32'h40);
        rd("polarity level", 8'h04, 32'h44);
        wr(8'h04, 32'h00);
        wr(GTC_OFS_IRQ_CLEAR, 32'h3f);
        wr(8'h08, 32'hf0);
        wr(8'h0c, 32'hff);
        wr(8'h00, 32'h01);
        repeat (30) @(posedge clk);
        wr(8'h00, 32'h00);
        cmp("overflow pulses", 32'(ovf_count), 32'h1);
        rd("overflow flag", GTC_OFS_IRQ_STATUS, 32'h2);
        $display("test overflow done");
        final_report();
    end
endmodule : test_gtc_gated_timer
